/* File: src/mba_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
module mba_arbiter (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Static configuration pins
   input wire logic [mba_pkg::IDX_W-1:0] processor_index,
   input wire logic rotating_priority_sel,
   // Shared request lines, one driven
   input wire logic [mba_pkg::NUM_LINES-1:0] arb_bus_request_n_in,
   output logic [mba_pkg::NUM_LINES-1:0] arb_bus_request_n_out,
   output logic [mba_pkg::NUM_LINES-1:0] arb_bus_request_oe,
   // Internal side: core wants the bus
   input wire logic core_bus_want,
   // Priority access, shared open line
   input wire logic priority_access_n_in,
   output logic priority_access_n_out,
   output logic priority_access_oe,
   input wire logic slave_priority_want,
   // Host handshakes
   input wire logic host_cs_n,
   input wire logic host_bus_request_n,
   output logic host_bus_grant_n_out,
   output logic host_bus_grant_oe,
   output logic host_ready_ack_n,
   output logic host_ready_ack_oe,
   // Bus float control toward address/data/strobes
   output logic ext_bus_float,
   output logic bus_master,
   // External DMA handshakes
   input wire logic ext_dma_request_one_n,
   input wire logic ext_dma_request_two_n,
   output logic ext_dma_grant_one_n,
   output logic ext_dma_grant_two_n,
   output logic ext_dma_grant_oe,
   output logic dma_start_one,
   output logic dma_start_two
);
   import mba_pkg::*;

   // ----------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync_q; // Reset release chain
   logic rst_n;            // Local reset copy
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rst_sync_q <= 2'b00;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   localparam int unsigned SW = IDX_W + NUM_LINES + 6; // Pins through synchroniser
   logic [SW-1:0] s1_q; // First stage, read only by stage two
   logic [SW-1:0] s2_q; // Stable copy
   logic [SW-1:0] raw;
   assign raw = {processor_index, rotating_priority_sel, ~arb_bus_request_n_in,
                 ~priority_access_n_in, ~host_cs_n, ~host_bus_request_n,
                 ~ext_dma_request_one_n, ~ext_dma_request_two_n};
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   logic [IDX_W-1:0] idx_s;
   logic rot_s, pa_s, cs_s, hbr_s, dr1_s, dr2_s;
   logic [NUM_LINES-1:0] req_s; // Active-high request lines
   assign {idx_s, rot_s, req_s, pa_s, cs_s, hbr_s, dr1_s, dr2_s} = s2_q;

   // ----------------------------------------
   // Static index capture
   // ----------------------------------------
   // Index caught once after reset release; later pin changes ignored
   logic [IDX_W-1:0] idx_q;
   logic idx_done_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idx_q <= IDX_NONE;
         idx_done_q <= 1'b0;
      end else if (!idx_done_q && rst_n) begin
         idx_q <= idx_s;
         idx_done_q <= 1'b1;
      end
   end

   // One-hot line of own index; 000 treated as line one
   function automatic logic [NUM_LINES-1:0] line_of(input logic [IDX_W-1:0] i);
      logic [NUM_LINES-1:0] r;
      r = '0;
      if (i == IDX_NONE) r[0] = 1'b1;
      else if (i <= IDX_LAST) r[i-IDX_FIRST] = 1'b1;
      return r;
   endfunction : line_of

   logic [NUM_LINES-1:0] own_line;
   assign own_line = line_of(idx_q);

   // ----------------------------------------
   // Arbitration
   // ----------------------------------------
   logic [NUM_LINES-1:0] last_q; // Most recent holder, one-hot
   logic [NUM_LINES-1:0] all_req;
   logic [NUM_LINES-1:0] winner_fix, winner_rot, winner;
   assign all_req = (req_s & ~own_line) | (own_line & {NUM_LINES{core_bus_want}});

   // Lowest set bit
   function automatic logic [NUM_LINES-1:0] lowest(input logic [NUM_LINES-1:0] v);
      return v & (~v + 1'b1);
   endfunction : lowest

   // Rotating: search from line after last holder, wrapping
   logic [2*NUM_LINES-1:0] dbl, mask_dbl, pick_dbl;
   assign mask_dbl = {{NUM_LINES{1'b1}}, ~((last_q << 1) - 1'b1) & ~last_q};
   assign dbl = {all_req, all_req} & mask_dbl;
   assign pick_dbl = dbl & (~dbl + 1'b1);
   assign winner_fix = lowest(all_req);
   // In rotating mode a peer that won keeps the bus while its line stays low; rotation
   // only moves on once the holder lets go, else it would be cut off
   logic peer_holds;
   assign peer_holds = |(last_q & ~own_line & req_s);
   assign winner_rot = peer_holds ? last_q :
                       (pick_dbl[NUM_LINES-1:0] | pick_dbl[2*NUM_LINES-1:NUM_LINES]);
   assign winner = rot_s ? winner_rot : winner_fix;

   logic own_wins;
   assign own_wins = |(winner & own_line) && core_bus_want && !pa_s && !hbr_s;

   // ----------------------------------------
   // Ownership state machine
   // ----------------------------------------
   mba_state_type st_q, st_d;
   always_comb begin
      st_d = st_q;
      case (st_q)
         MBA_IDLE: if (own_wins) st_d = MBA_MASTER;
         // Host first, then a slave's priority access, then give up when done
         MBA_MASTER: begin
            if (hbr_s) st_d = MBA_RELEASE;
            else if (pa_s && !slave_priority_want) st_d = MBA_IDLE;
            else if (!core_bus_want) st_d = MBA_IDLE;
         end
         MBA_RELEASE: st_d = hbr_s ? MBA_HOSTGNT : MBA_IDLE;
         MBA_HOSTGNT: if (!hbr_s) st_d = MBA_IDLE;
         default: st_d = MBA_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) st_q <= MBA_IDLE;
      else st_q <= st_d;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) last_q <= LINES_IDLE;
      else if (st_q == MBA_MASTER) last_q <= own_line;
      else if (|winner) last_q <= winner;
   end

   assign bus_master = (st_q == MBA_MASTER);
   assign ext_bus_float = (st_q != MBA_MASTER);
   assign host_bus_grant_n_out = (st_q != MBA_HOSTGNT);
   assign host_bus_grant_oe = (st_q == MBA_RELEASE) || (st_q == MBA_HOSTGNT);

   // Own line only ever driven; others left as inputs
   assign arb_bus_request_oe = own_line;
   assign arb_bus_request_n_out = ~(own_line & {NUM_LINES{core_bus_want}});
   // Open-drain: enable only while pulling low
   assign priority_access_oe = slave_priority_want && !bus_master;
   assign priority_access_n_out = 1'b0;

   // ----------------------------------------
   // Host ready wait states
   // ----------------------------------------
   logic [2:0] wait_q;
   logic host_sel;
   assign host_sel = cs_s && hbr_s;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wait_q <= 3'h0;
      else if (!host_sel) wait_q <= 3'h0;
      else if (wait_q != WAIT_CYCLES) wait_q <= wait_q + 3'h1;
   end
   assign host_ready_ack_oe = host_sel && (wait_q != WAIT_CYCLES);
   assign host_ready_ack_n = 1'b0;

   // ----------------------------------------
   // External DMA grants
   // ----------------------------------------
   // Grant pulses one cycle, the start strobe follows next cycle
   logic g1_q, g2_q, st1_q, st2_q;
   logic dma_ok;
   assign dma_ok = bus_master && !pa_s;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         g1_q <= 1'b0;
         g2_q <= 1'b0;
         st1_q <= 1'b0;
         st2_q <= 1'b0;
      end else begin
         g1_q <= dma_ok && dr1_s && !g1_q && !st1_q;
         g2_q <= dma_ok && dr2_s && !dr1_s && !g2_q && !st2_q;
         st1_q <= g1_q;
         st2_q <= g2_q;
      end
   end
   assign ext_dma_grant_one_n = ~g1_q;
   assign ext_dma_grant_two_n = ~g2_q;
   assign ext_dma_grant_oe = bus_master;
   assign dma_start_one = st1_q;
   assign dma_start_two = st2_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_grant_leads_start: assert property (@(posedge clk) disable iff (!rst_n)
      g1_q |=> st1_q) else $error("start did not follow grant");
   a_grant_only_master: assert property (@(posedge clk) disable iff (!rst_n)
      !bus_master |-> !ext_dma_grant_oe) else $error("grant driven when not master");
   a_own_line_only: assert property (@(posedge clk) disable iff (!rst_n)
      $onehot(arb_bus_request_oe)) else $error("drives more than one request line");
   a_host_grant_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == MBA_HOSTGNT) && hbr_s |=> !host_bus_grant_n_out) else $error("grant dropped");
   a_release_first: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(host_bus_grant_n_out) |-> $past(ext_bus_float)) else $error("grant before float");
   a_ready_wait: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(host_sel) |-> host_ready_ack_oe ##1 (host_ready_ack_oe || !host_sel)
      ##1 !host_ready_ack_oe)
      else $error("wait states wrong");
   a_index_static: assert property (@(posedge clk) disable iff (!rst_n)
      idx_done_q |=> $stable(idx_q)) else $error("index changed");
   a_pa_yields: assert property (@(posedge clk) disable iff (!rst_n)
      bus_master && pa_s |=> !g1_q && !g2_q) else $error("DMA during priority access");
   a_fixed_lowest: assert property (@(posedge clk) disable iff (!rst_n)
      !rot_s && all_req[0] |-> winner[0]) else $error("fixed priority wrong");
   c_become_master: cover property (@(posedge clk) disable iff (!rst_n) $rose(bus_master));
   c_host_grant: cover property (@(posedge clk) disable iff (!rst_n) st_q == MBA_HOSTGNT);
   c_dma_one: cover property (@(posedge clk) disable iff (!rst_n) g1_q ##1 st1_q);
   c_rotating: cover property (@(posedge clk) disable iff (!rst_n) rot_s && bus_master);
endmodule : mba_arbiter
`default_nettype wire

/* File: src/mba_pkg.sv */
package mba_pkg;
   // ----------------------------------------
   // Sizes and encodings
   // ----------------------------------------
   localparam int unsigned NUM_LINES = 6;      // Shared request lines
   localparam int unsigned IDX_W = 3;          // Processor index width
   localparam logic [2:0] IDX_NONE = 3'h0;     // Single-processor index
   localparam logic [2:0] IDX_FIRST = 3'h1;    // Index of line one
   localparam logic [2:0] IDX_LAST = 3'h6;     // Index of line six
   localparam logic [5:0] LINES_IDLE = 6'h00;  // No request active
   localparam logic [2:0] WAIT_CYCLES = 3'h2;  // Host wait states inserted

   // Bus ownership states
   typedef enum logic [1:0] {
      MBA_IDLE = 2'b00,    // Not owner
      MBA_MASTER = 2'b01,  // Own the external bus
      MBA_RELEASE = 2'b10, // Floating lines before host grant
      MBA_HOSTGNT = 2'b11  // Host grant asserted
   } mba_state_type;
endpackage : mba_pkg

/* File: testbench/mba_far_side.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Peers, host and DMA devices on the far side
// ----------------------------------------
module mba_far_side (
   // Commands from the bench
   input wire logic [5:0] peer_want,
   input wire logic peer_pa,
   input wire logic host_want,
   input wire logic host_sel,
   input wire logic dma_one,
   input wire logic dma_two,
   // Device drive of shared lines
   input wire logic [5:0] req_out,
   input wire logic [5:0] req_oe,
   input wire logic pa_out,
   input wire logic pa_oe,
   // Resolved pins toward the device
   output logic [5:0] req_lines,
   output logic pa_line,
   output logic hbr_n,
   output logic cs_n,
   output logic dma_one_n,
   output logic dma_two_n
);
   // Pulled-up open lines: low if anyone pulls
   assign req_lines = ~(peer_want | (req_oe & ~req_out));
   assign pa_line = ~(peer_pa | (pa_oe & ~pa_out));
   // Host selects with a low chip select
   assign hbr_n = ~host_want;
   assign cs_n = ~host_sel;
   // Peripheral requests for channels 11 and 12
   assign dma_one_n = ~dma_one;
   assign dma_two_n = ~dma_two;
endmodule : mba_far_side
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mba_pkg::*;
   // ----------------------------------------
   // Bench state and pins
   // ----------------------------------------
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   int mismatches = 0;
   int n_compared = 0;
   logic core_want = 1'b0;
   logic slave_want = 1'b0;
   logic rot_sel = 1'b0;
   logic [2:0] idx_pin = 3'h2;
   // Codes of the outputs that wait_lv can watch
   localparam int W_MST = 0, W_G1 = 1, W_G2 = 2, W_RDY = 3, W_HBG = 4, W_HBG_OE = 5;
   logic [5:0] peer_want = 6'h00;
   logic peer_pa = 1'b0, host_want = 1'b0, host_sel = 1'b0, dma_one = 1'b0, dma_two = 1'b0;
   logic [5:0] req_in, req_out, req_oe;
   logic pa_in, pa_out, pa_oe, hbr_n, cs_n, d1_n, d2_n, hbg_n, hbg_oe, rdy_n, rdy_oe;
   logic flt, mst, g1_n, g2_n, g_oe, st1, st2;
   // Clock, 8 ns period
   initial begin
      forever #4 clk = ~clk;
   end
   // Device as processor two, fixed priority (static pins)
   mba_arbiter u_mba_arbiter (.clk(clk), .arst_n(arst_n), .processor_index(idx_pin),
      .rotating_priority_sel(rot_sel), .arb_bus_request_n_in(req_in),
      .arb_bus_request_n_out(req_out), .arb_bus_request_oe(req_oe), .core_bus_want(core_want),
      .priority_access_n_in(pa_in), .priority_access_n_out(pa_out), .priority_access_oe(pa_oe),
      .slave_priority_want(slave_want), .host_cs_n(cs_n), .host_bus_request_n(hbr_n),
      .host_bus_grant_n_out(hbg_n), .host_bus_grant_oe(hbg_oe), .host_ready_ack_n(rdy_n),
      .host_ready_ack_oe(rdy_oe), .ext_bus_float(flt), .bus_master(mst),
      .ext_dma_request_one_n(d1_n), .ext_dma_request_two_n(d2_n), .ext_dma_grant_one_n(g1_n),
      .ext_dma_grant_two_n(g2_n), .ext_dma_grant_oe(g_oe), .dma_start_one(st1),
      .dma_start_two(st2));
   mba_far_side u_mba_far_side (.peer_want(peer_want), .peer_pa(peer_pa),
      .host_want(host_want), .host_sel(host_sel), .dma_one(dma_one), .dma_two(dma_two),
      .req_out(req_out), .req_oe(req_oe), .pa_out(pa_out), .pa_oe(pa_oe), .req_lines(req_in),
      .pa_line(pa_in), .hbr_n(hbr_n), .cs_n(cs_n), .dma_one_n(d1_n), .dma_two_n(d2_n));
   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Current level of a watched output, by code
   function automatic logic sig_of(input int w);
      case (w)
         W_MST: return mst;
         W_G1: return g1_n;
         W_G2: return g2_n;
         W_RDY: return rdy_oe;
         W_HBG: return hbg_n;
         default: return hbg_oe;
      endcase
   endfunction : sig_of
   // Bounded wait, one step past the edge so updates have landed
   task automatic wait_lv(input int w, input logic v, input int n);
      int i;
      i = 0;
      while (sig_of(w) !== v && i < n) begin
         @(posedge clk);
         #1;
         i++;
      end
   endtask : wait_lv
   task automatic final_report;
      $display("Compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_idle;
      chk("grant_oe", 6'h00, {5'h00, g_oe});
      chk("req_oe", 6'h02, req_oe);
      chk("float", 6'h01, {5'h00, flt});
      slave_want = 1'b1;
      @(posedge clk);
      #1;
      chk("pa_drive", 6'h02, {4'h0, pa_oe, pa_out});
      slave_want = 1'b0;
   endtask : t_idle
   // Line one outranks us; we win only once it drops
   task automatic t_fixed;
      peer_want = 6'h01;
      repeat (3) @(posedge clk);
      #1;
      core_want = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      chk("master_lost", 6'h00, {5'h00, mst});
      peer_want = 6'h00;
      wait_lv(W_MST, 1'b1, 12);
      chk("master_won", 6'h01, {5'h00, mst});
      chk("own_line", 6'h02, req_oe & ~req_out);
   endtask : t_fixed
   // Both channels at once: one first, then two; start follows each grant
   task automatic t_dma;
      dma_one = 1'b1;
      dma_two = 1'b1;
      wait_lv(W_G1, 1'b0, 10);
      chk("grant_one", 6'h00, {5'h00, g1_n});
      chk("order_two_waits", 6'h01, {5'h00, g2_n});
      chk("grant_oe_m", 6'h01, {5'h00, g_oe});
      dma_one = 1'b0;
      @(posedge clk);
      #1;
      chk("start_one", 6'h01, {5'h00, st1});
      wait_lv(W_G2, 1'b0, 10);
      chk("grant_two_on", 6'h00, {5'h00, g2_n});
      dma_two = 1'b0;
      @(posedge clk);
      #1;
      chk("start_two", 6'h01, {5'h00, st2});
   endtask : t_dma
   // Slave priority access blocks DMA and takes the bus
   task automatic t_pa;
      peer_pa = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      dma_two = 1'b1;
      repeat (6) begin
         @(posedge clk);
         #1;
         chk("grant_two", 6'h01, {5'h00, g2_n});
      end
      wait_lv(W_MST, 1'b0, 10);
      chk("pa_yield", 6'h00, {5'h00, mst});
      dma_two = 1'b0;
      peer_pa = 1'b0;
   endtask : t_pa
   // Host wins, waits are inserted, grant holds until release
   task automatic t_host;
      wait_lv(W_MST, 1'b1, 12);
      host_want = 1'b1;
      host_sel = 1'b1;
      wait_lv(W_RDY, 1'b1, 6);
      chk("ready_wait", 6'h02, {4'h0, rdy_oe, rdy_n});
      wait_lv(W_HBG, 1'b0, 8);
      chk("ready_done", 6'h00, {5'h00, rdy_oe});
      chk("host_grant", 6'h02, {4'h0, hbg_oe, hbg_n});
      chk("host_float", 6'h02, {4'h0, flt, mst});
      chk("host_dma_oe", 6'h00, {5'h00, g_oe});
      repeat (10) @(posedge clk);
      #1;
      chk("grant_hold", 6'h02, {4'h0, hbg_oe, hbg_n});
      host_want = 1'b0;
      host_sel = 1'b0;
      wait_lv(W_HBG_OE, 1'b0, 8);
      chk("grant_drop", 6'h00, {5'h00, hbg_oe});
   endtask : t_host
   // Rotating: line three wins after we held the bus, though we rank higher
   task automatic t_rot;
      rot_sel = 1'b1;
      core_want = 1'b0;
      peer_want = 6'h04;
      repeat (4) @(posedge clk);
      #1;
      core_want = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk("rot_lost", 6'h00, {5'h00, mst});
      peer_want = 6'h00;
      wait_lv(W_MST, 1'b1, 12);
      chk("rot_won", 6'h01, {5'h00, mst});
      rot_sel = 1'b0;
      core_want = 1'b0;
   endtask : t_rot
   // Index pin ignored until a reset, then taken up
   task automatic t_index;
      idx_pin = 3'h4;
      repeat (5) @(posedge clk);
      #1;
      chk("idx_static", 6'h02, req_oe);
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk("idx_reset", 6'h08, req_oe);
   endtask : t_index
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      t_idle();
      t_fixed();
      t_dma();
      t_pa();
      t_host();
      t_rot();
      t_index();
      final_report();
   end
   // Whole run needs under two hundred cycles
   initial begin
      #(8 * 2000);
      mismatches++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
